/* core/ipefb_pkg.sv */
/*
 * Constants for the interrupt priority, enable and pending-flag bank.
 * Assumes a 32-bit APB with word-aligned registers, byte address = 4 * index.
 */
package ipefb_pkg;

   // ==========================================================
   // Bus geometry
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IDX_W  = 16;

   // ==========================================================
   // Register indices (byte address is four times these)
   localparam logic [IDX_W-1:0] IDX_LVL_KT  = 16'hff20;
   localparam logic [IDX_W-1:0] IDX_LVL_PER = 16'hff21;
   localparam logic [IDX_W-1:0] IDX_EN_KEY  = 16'hff23;
   localparam logic [IDX_W-1:0] IDX_EN_TS   = 16'hff24;
   localparam logic [IDX_W-1:0] IDX_EN_CD   = 16'hff25;
   localparam logic [IDX_W-1:0] IDX_PEND    = 16'hff27;
   localparam logic [IDX_W-1:0] IDX_STS     = 16'hff2e;
   localparam logic [IDX_W-1:0] IDX_MSK     = 16'hff2f;

   // ==========================================================
   // Reset values and implemented-bit masks
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [7:0] KEY_BITS  = 8'hf8;
   localparam logic [7:0] CD_BITS   = 8'hfc;
   localparam logic [1:0] WORD_LSB  = 2'h0;

   // ==========================================================
   // Groups in fixed default order, index 0 is the most urgent
   localparam int unsigned NGRP      = 8;
   localparam int unsigned GW        = 3;
   localparam int unsigned GRP_KEY1  = 0;
   localparam int unsigned GRP_KEY0  = 1;
   localparam int unsigned GRP_TM0   = 2;
   localparam int unsigned GRP_TM1   = 3;
   localparam int unsigned GRP_NTM   = 4;
   localparam int unsigned GRP_SER   = 5;
   localparam int unsigned GRP_LCD   = 6;
   localparam int unsigned GRP_TICK  = 7;

   // Two-bit level slots, slot 3 sits in bits 7:6
   localparam int unsigned SLOT_KEY1 = 3;
   localparam int unsigned SLOT_KEY0 = 2;
   localparam int unsigned SLOT_TM1  = 1;
   localparam int unsigned SLOT_TM0  = 0;
   localparam int unsigned SLOT_NTM  = 3;
   localparam int unsigned SLOT_SER  = 2;
   localparam int unsigned SLOT_TICK = 1;
   localparam int unsigned SLOT_LCD  = 0;

   // Level codes: 11 level 3 ... 00 no interrupt
   localparam logic [1:0] LVL_NONE = 2'h0;

   // Picks one two-bit level field from a level byte
   function automatic logic [1:0] level_field(input logic [7:0] b,
                                              input int unsigned slot);
      level_field = b[slot*2 +: 2];
   endfunction

endpackage

/* core/ipefb_arbiter.sv */
/*
 * Level arbiter: picks the pending group of highest level above the CPU mask.
 * Assumes requests and levels are steady within a cycle; purely combinational.
 */
`timescale 1ns/1ps

module ipefb_arbiter #(
   parameter int unsigned NGRP = 8,
   parameter int unsigned GW   = 3
) (
   input  wire logic [NGRP-1:0]   req,
   input  wire logic [2*NGRP-1:0] lvl,
   input  wire logic [1:0]        mask,
   output logic                   win,
   output logic [GW-1:0]          win_grp,
   output logic [1:0]             win_lvl
);

   // ==========================================================
   // Search
   // Best starts at the mask so only strictly higher levels win; a
   // tie keeps the lower index, which is the fixed default order.
   always_comb begin
      logic [1:0] best;
      best    = mask;
      win     = 1'b0;
      win_grp = '0;
      for (int unsigned i = 0; i < NGRP; i++) begin
         if (req[i] && (lvl[2*i +: 2] > best)) begin
            best    = lvl[2*i +: 2];
            win     = 1'b1;
            win_grp = GW'(i);
         end
      end
      win_lvl = best;
   end

endmodule

/* core/ipefb_top.sv */
/*
 * Interrupt priority, enable and key pending-flag bank with an APB slave.
 * Assumes event sources give one-cycle pulses for the keys and steady
 * pending levels for the other sources, whose flags live elsewhere.
 */
// The APB slave port was decided locally.
`timescale 1ns/1ps

// Contract
// - Two level bytes hold key group 1, key group 0, timer 1, timer 0 and then 8-bit timer, serial, clock timer, LCD, high to low.
// - Each two-bit level field means 11 level 3 down to 00 no interrupt, is read/write and resets to zero.
// - The key enable byte holds keys 13 to 10 and key group 0 in bits 7 to 3, with bits 2 to 0 reading zero.
// - The timer byte holds 8-bit underflow, timer 1 match, timer 1 underflow, timer 0 match and timer 0 underflow enables in bits 7 to 3.
// - Bits 2, 1 and 0 of that byte enable serial transmit done, receive done and receive error, all read/write.
// - The clock byte holds minute, 1 Hz, 2 Hz, 8 Hz, 32 Hz and display transfer enables in bits 7 to 2, with bits 1 and 0 reading zero.
// - Every enable resets to zero and reads back as written.
// - The key pending byte shows keys 13 to 10 and key group 0 in bits 7 to 3, resets to zero, and bits 2 to 0 read zero.
// - Writing one to a pending bit clears it and writing zero leaves it.
// - A request is offered only when its level is strictly above the CPU mask level.
// - Equal levels are settled by the fixed default order of the groups.
module ipefb_top #(
   parameter int unsigned ADDR_W = ipefb_pkg::ADDR_W
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [7:3]        key_event,
   input  wire logic [7:0]        ts_pending,
   input  wire logic [7:2]        cd_pending,
   input  wire logic [1:0]        cpu_mask,
   output logic                   cpu_irq_req,
   output logic [2:0]             cpu_irq_grp,
   output logic [1:0]             cpu_irq_lvl,
   output logic                   irq
);

   // ==========================================================
   // Storage
   logic [7:0]  lvl_kt_q;
   logic [7:0]  lvl_per_q;
   logic [7:0]  en_key_q;
   logic [7:0]  en_ts_q;
   logic [7:0]  en_cd_q;
   logic [7:0]  pend_q;
   logic [7:0]  pend_d;
   logic [7:0]  sts_q;
   logic [7:0]  sts_d;
   logic [7:0]  msk_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        req_q;
   logic [2:0]  grp_q;
   logic [1:0]  lvl_q;
   logic        irq_q;
   logic [7:0]  grp_req_q;

   // ==========================================================
   // Bus decode
   logic                          setup;
   logic                          wr_go;
   logic [ipefb_pkg::IDX_W-1:0]   idx;
   logic                          hit;
   logic [7:0]                    rd_byte;
   logic [7:0]                    wb;

   assign setup = psel && !penable;
   assign idx   = paddr[ipefb_pkg::IDX_W+1:2];
   assign wb    = pwdata[7:0];
   // Only lane 0 carries data; a write without it changes nothing
   assign wr_go = psel && penable && pready_q && pwrite &&
                  !pslverr_q && pstrb[0];

   // Read mux; unimplemented bits come back as zero
   always_comb begin
      hit     = 1'b1;
      rd_byte = ipefb_pkg::RST_BYTE;
      unique case (idx)
         ipefb_pkg::IDX_LVL_KT:  rd_byte = lvl_kt_q;
         ipefb_pkg::IDX_LVL_PER: rd_byte = lvl_per_q;
         ipefb_pkg::IDX_EN_KEY:  rd_byte = en_key_q;
         ipefb_pkg::IDX_EN_TS:   rd_byte = en_ts_q;
         ipefb_pkg::IDX_EN_CD:   rd_byte = en_cd_q;
         ipefb_pkg::IDX_PEND:    rd_byte = pend_q;
         ipefb_pkg::IDX_STS:     rd_byte = sts_q;
         ipefb_pkg::IDX_MSK:     rd_byte = msk_q;
         default:                hit     = 1'b0;
      endcase
   end

   // ==========================================================
   // APB answer
   // Data is captured in the setup cycle so that every output is a
   // flop; the cost is one access cycle with no extra wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup &&
                      (!hit || (paddr[1:0] != ipefb_pkg::WORD_LSB) ||
                       ((paddr >> (ipefb_pkg::IDX_W + 2)) != '0));
         if (setup && !pwrite) begin
            prdata_q <= {24'h000000, rd_byte};
         end else if (!setup) begin
            prdata_q <= '0;
         end
      end
   end

   // ==========================================================
   // Level registers, 2-bit fields, all read/write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_kt_q  <= ipefb_pkg::RST_BYTE;
         lvl_per_q <= ipefb_pkg::RST_BYTE;
      end else if (wr_go) begin
         if (idx == ipefb_pkg::IDX_LVL_KT) begin
            lvl_kt_q <= wb;
         end
         if (idx == ipefb_pkg::IDX_LVL_PER) begin
            lvl_per_q <= wb;
         end
      end
   end

   // ==========================================================
   // Enable registers; reserved bits never store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_key_q <= ipefb_pkg::RST_BYTE;
         en_ts_q  <= ipefb_pkg::RST_BYTE;
         en_cd_q  <= ipefb_pkg::RST_BYTE;
      end else if (wr_go) begin
         if (idx == ipefb_pkg::IDX_EN_KEY) begin
            en_key_q <= wb & ipefb_pkg::KEY_BITS;
         end
         if (idx == ipefb_pkg::IDX_EN_TS) begin
            en_ts_q <= wb;
         end
         if (idx == ipefb_pkg::IDX_EN_CD) begin
            en_cd_q <= wb & ipefb_pkg::CD_BITS;
         end
      end
   end

   // ==========================================================
   // Key pending flags
   // Clear applies first and the event after it, so an event in the
   // clearing cycle is never lost.
   always_comb begin
      pend_d = pend_q;
      if (wr_go && (idx == ipefb_pkg::IDX_PEND)) begin
         pend_d = pend_q & ~wb;
      end
      pend_d = (pend_d | {key_event, 3'h0}) &
               ipefb_pkg::KEY_BITS;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= ipefb_pkg::RST_BYTE;
      end else begin
         pend_q <= pend_d;
      end
   end

   // ==========================================================
   // Group requests: pending and enabled, one bit per group
   logic [7:0]  grp_req;
   logic [15:0] grp_lvl;
   logic [7:0]  ts_on;
   logic [7:0]  cd_on;

   assign ts_on = ts_pending & en_ts_q;
   assign cd_on = {cd_pending, 2'h0} & en_cd_q;

   always_comb begin
      grp_req = '0;
      grp_req[ipefb_pkg::GRP_KEY1] = |(pend_q[7:4] & en_key_q[7:4]);
      grp_req[ipefb_pkg::GRP_KEY0] = pend_q[3] & en_key_q[3];
      grp_req[ipefb_pkg::GRP_TM0]  = |ts_on[4:3];
      grp_req[ipefb_pkg::GRP_TM1]  = |ts_on[6:5];
      grp_req[ipefb_pkg::GRP_NTM]  = ts_on[7];
      grp_req[ipefb_pkg::GRP_SER]  = |ts_on[2:0];
      grp_req[ipefb_pkg::GRP_LCD]  = cd_on[2];
      grp_req[ipefb_pkg::GRP_TICK] = |cd_on[7:3];
   end

   // Level vector indexed by group, taken from the two level bytes
   always_comb begin
      grp_lvl = '0;
      grp_lvl[2*ipefb_pkg::GRP_KEY1 +: 2] =
         ipefb_pkg::level_field(lvl_kt_q, ipefb_pkg::SLOT_KEY1);
      grp_lvl[2*ipefb_pkg::GRP_KEY0 +: 2] =
         ipefb_pkg::level_field(lvl_kt_q, ipefb_pkg::SLOT_KEY0);
      grp_lvl[2*ipefb_pkg::GRP_TM1 +: 2] =
         ipefb_pkg::level_field(lvl_kt_q, ipefb_pkg::SLOT_TM1);
      grp_lvl[2*ipefb_pkg::GRP_TM0 +: 2] =
         ipefb_pkg::level_field(lvl_kt_q, ipefb_pkg::SLOT_TM0);
      grp_lvl[2*ipefb_pkg::GRP_NTM +: 2] =
         ipefb_pkg::level_field(lvl_per_q, ipefb_pkg::SLOT_NTM);
      grp_lvl[2*ipefb_pkg::GRP_SER +: 2] =
         ipefb_pkg::level_field(lvl_per_q, ipefb_pkg::SLOT_SER);
      grp_lvl[2*ipefb_pkg::GRP_TICK +: 2] =
         ipefb_pkg::level_field(lvl_per_q, ipefb_pkg::SLOT_TICK);
      grp_lvl[2*ipefb_pkg::GRP_LCD +: 2] =
         ipefb_pkg::level_field(lvl_per_q, ipefb_pkg::SLOT_LCD);
   end

   // ==========================================================
   // Arbitration toward the CPU
   logic       win;
   logic [2:0] win_grp;
   logic [1:0] win_lvl;

   ipefb_arbiter #(
      .NGRP (ipefb_pkg::NGRP),
      .GW   (ipefb_pkg::GW)
   ) u_arb (
      .req     (grp_req),
      .lvl     (grp_lvl),
      .mask    (cpu_mask),
      .win     (win),
      .win_grp (win_grp),
      .win_lvl (win_lvl)
   );

   // Registered request; level 00 never passes since mask is at least 00
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q <= 1'b0;
         grp_q <= '0;
         lvl_q <= ipefb_pkg::LVL_NONE;
      end else begin
         req_q <= win;
         grp_q <= win ? win_grp : '0;
         lvl_q <= win ? win_lvl : ipefb_pkg::LVL_NONE;
      end
   end

   // ==========================================================
   // Event status: a group whose request newly appears sets its bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grp_req_q <= '0;
      end else begin
         grp_req_q <= grp_req;
      end
   end

   // New events win over a write-one clear in the same cycle
   always_comb begin
      sts_d = sts_q;
      if (wr_go && (idx == ipefb_pkg::IDX_STS)) begin
         sts_d = sts_q & ~wb;
      end
      sts_d = sts_d | (grp_req & ~grp_req_q);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= ipefb_pkg::RST_BYTE;
         msk_q <= ipefb_pkg::RST_BYTE;
         irq_q <= 1'b0;
      end else begin
         sts_q <= sts_d;
         if (wr_go && (idx == ipefb_pkg::IDX_MSK)) begin
            msk_q <= wb;
         end
         irq_q <= |(sts_d & msk_q);
      end
   end

   // ==========================================================
   // Outputs, each straight from a flop
   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign cpu_irq_req = req_q;
   assign cpu_irq_grp = grp_q;
   assign cpu_irq_lvl = lvl_q;
   assign irq         = irq_q;

   // ==========================================================
   // Checks
   property p_evt_sets;
      @(posedge pclk) disable iff (!presetn)
      (key_event != '0) |=>
         ((pend_q[7:3] & $past(key_event)) == $past(key_event));
   endproperty
   a_evt_sets: assert property (p_evt_sets)
      else $error("key event did not set its pending flag");

   property p_w1c;
      @(posedge pclk) disable iff (!presetn)
      (wr_go && idx == ipefb_pkg::IDX_PEND && key_event == '0) |=>
         ((pend_q & $past(wb)) == 8'h00) &&
         ((pend_q | $past(wb)) == ($past(pend_q) | $past(wb)));
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("pending write-one clear misbehaved");

   property p_rsvd_zero;
      @(posedge pclk) disable iff (!presetn)
      (pend_q[2:0] == 3'h0) && (en_key_q[2:0] == 3'h0) &&
      (en_cd_q[1:0] == 2'h0);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved bit became set");

   property p_above_mask;
      @(posedge pclk) disable iff (!presetn)
      cpu_irq_req |-> (cpu_irq_lvl > $past(cpu_mask));
   endproperty
   a_above_mask: assert property (p_above_mask)
      else $error("request offered at or below the mask");

   property p_no_enable_no_req;
      @(posedge pclk) disable iff (!presetn)
      (en_key_q == 8'h00 && en_ts_q == 8'h00 && en_cd_q == 8'h00)
         |=> !cpu_irq_req;
   endproperty
   a_no_enable_no_req: assert property (p_no_enable_no_req)
      else $error("request raised with every enable clear");

   property p_grp_level;
      @(posedge pclk) disable iff (!presetn)
      cpu_irq_req |->
         ($past(grp_lvl) >> (2*cpu_irq_grp)) % 4 == 32'(cpu_irq_lvl);
   endproperty
   a_grp_level: assert property (p_grp_level)
      else $error("winning level does not match its group");

   property p_tie_first;
      @(posedge pclk) disable iff (!presetn)
      (cpu_irq_req && cpu_irq_grp != 3'h0) |->
         !($past(grp_req[0]) && $past(grp_lvl[1:0]) >= cpu_irq_lvl);
   endproperty
   a_tie_first: assert property (p_tie_first)
      else $error("group 0 lost a tie or a higher level");

   property p_ready_once;
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready;
   endproperty
   a_ready_once: assert property (p_ready_once)
      else $error("pready not a single access cycle");

   property p_enable_readback;
      @(posedge pclk) disable iff (!presetn)
      (wr_go && idx == ipefb_pkg::IDX_EN_TS) |=> en_ts_q == $past(wb);
   endproperty
   a_enable_readback: assert property (p_enable_readback)
      else $error("timer and serial enable byte did not store");

endmodule

/* tb/ipefb_cpu_model.sv */
/*
 * CPU-side partner: holds the two interrupt mask flags and accepts requests.
 * Assumes the bank's request outputs are registered on pclk.
 */
`timescale 1ns/1ps

module ipefb_cpu_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       cpu_irq_req,
   input  wire logic [2:0] cpu_irq_grp,
   input  wire logic [1:0] cpu_irq_lvl,
   input  wire logic [1:0] mask_set,
   input  wire logic       mask_load,
   input  wire logic       accept_en,
   output logic [1:0]      cpu_mask,
   output logic [2:0]      acc_grp,
   output logic            accepted
);
   logic [1:0] mask_q;
   logic [2:0] acc_grp_q;
   logic       accepted_q;

   // ==========================================================
   // Mask flags and acceptance
   // Taking a request raises the mask to its level, so equal levels wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q     <= 2'h0;
         acc_grp_q  <= 3'h0;
         accepted_q <= 1'b0;
      end else if (mask_load) begin
         mask_q     <= mask_set;
         accepted_q <= 1'b0;
      end else if (accept_en && cpu_irq_req && !accepted_q) begin
         mask_q     <= cpu_irq_lvl;
         acc_grp_q  <= cpu_irq_grp;
         accepted_q <= 1'b1;
      end
   end

   // Outputs straight from the flops
   assign cpu_mask = mask_q;
   assign acc_grp  = acc_grp_q;
   assign accepted = accepted_q;
endmodule

/* tb/irq_priority_enable_flag_bank_bench.sv */
/*
 * Self-checking bench for the interrupt priority, enable and pending bank.
 * Assumes the APB slave answers with pready and a 1-cycle CPU-side latency.
 */
`timescale 1ns/1ps

module irq_priority_enable_flag_bank_bench;
   logic                            pclk, presetn, psel, penable, pwrite;
   logic [ipefb_pkg::ADDR_W-1:0]   paddr;
   logic [31:0]                     pwdata, prdata, r;
   logic [3:0]                      pstrb;
   logic                            pready, pslverr, e, irq;
   logic [7:3]                      key_event;
   logic [7:0]                      ts_pending;
   logic [7:2]                      cd_pending;
   logic [1:0]                      cpu_mask, cpu_irq_lvl, mask_set;
   logic                            cpu_irq_req, mask_load, accept_en, accepted;
   logic [2:0]                      cpu_irq_grp, acc_grp;
   int                              mismatches, n_compared, cycles;
   logic [15:0] idx_t [8] = '{16'hff20, 16'hff21, 16'hff23, 16'hff24,
                              16'hff25, 16'hff27, 16'hff2e, 16'hff2f};
   logic [7:0]  rw_t [8]  = '{8'hff, 8'hff, 8'hf8, 8'hff, 8'hfc, 8'h00, 8'h00, 8'hff};
   logic [2:0]  grp_t [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4, 3'h5, 3'h7, 3'h6};

   ipefb_top #(.ADDR_W(ipefb_pkg::ADDR_W)) ipefb_top_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .key_event(key_event), .ts_pending(ts_pending), .cd_pending(cd_pending),
      .cpu_mask(cpu_mask), .cpu_irq_req(cpu_irq_req), .cpu_irq_grp(cpu_irq_grp),
      .cpu_irq_lvl(cpu_irq_lvl), .irq(irq));

   ipefb_cpu_model ipefb_cpu_model_inst (
      .pclk(pclk), .presetn(presetn), .cpu_irq_req(cpu_irq_req),
      .cpu_irq_grp(cpu_irq_grp), .cpu_irq_lvl(cpu_irq_lvl), .mask_set(mask_set),
      .mask_load(mask_load), .accept_en(accept_en), .cpu_mask(cpu_mask),
      .acc_grp(acc_grp), .accepted(accepted));

   // ==========================================================
   // Clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // A few hundred transfers at most, so 20000 cycles means a hang
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end

   // ==========================================================
   // Checking and bus tasks
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer; ev pulses key events at the access edge
   task automatic xfer(input logic [15:0] idx, input logic wr, input logic [7:0] wd,
                       input logic [7:3] ev);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'h0};
      pwdata  <= {24'h0, wd};
      @(posedge pclk);
      penable   <= 1'b1;
      key_event <= ev;
      @(posedge pclk);
      // No fixed wait count: only the bench hang guard ends a stall
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      key_event <= 5'h0;
      psel      <= 1'b0;
      penable   <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
      xfer(idx, 1'b0, 8'h0, 5'h0);
      chk(nm, exp, r);
   endtask

   // Request outputs trail the state by one cycle, so let three edges pass
   task automatic cpu_chk(input logic q, input logic [2:0] g, input logic [1:0] l);
      repeat (3) @(posedge pclk);
      chk("cpu_irq_req", {31'h0, q}, {31'h0, cpu_irq_req});
      chk("cpu_irq_grp", {29'h0, g}, {29'h0, cpu_irq_grp});
      chk("cpu_irq_lvl", {30'h0, l}, {30'h0, cpu_irq_lvl});
   endtask

   task automatic set_mask(input logic [1:0] m);
      @(posedge pclk);
      mask_set  <= m;
      mask_load <= 1'b1;
      @(posedge pclk);
      mask_load <= 1'b0;
   endtask

   task automatic complete_run();
      if (mismatches == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      key_event = 5'h0;
      ts_pending = 8'h0;
      cd_pending = 6'h0;
      mask_set = 2'h0;
      mask_load = 1'b0;
      accept_en = 1'b0;
      mismatches = 0;
      n_compared = 0;
      cycles = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) rd_chk("reset value", idx_t[i], 32'h0);
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 8; i++) begin
            if (i != 5 && i != 6) begin
               xfer(idx_t[i], 1'b1, j ? 8'h00 : 8'hff, 5'h0);
               rd_chk("read back", idx_t[i], j ? 32'h0 : {24'h0, rw_t[i]});
            end
         end
      end
      // Lane 0 strobe off: the write is dropped without an error
      pstrb <= 4'he;
      xfer(ipefb_pkg::IDX_MSK, 1'b1, 8'h5a, 5'h0);
      pstrb <= 4'hf;
      rd_chk("lane 0 off", ipefb_pkg::IDX_MSK, 32'h0);
      // Unmapped word: error, no data
      xfer(16'hff22, 1'b1, 8'hff, 5'h0);
      xfer(16'hff22, 1'b0, 8'h0, 5'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
      // Pending flags: set, write-one clear, event beats clear
      xfer(ipefb_pkg::IDX_EN_TS, 1'b0, 8'h0, 5'b10101);
      rd_chk("pending set", ipefb_pkg::IDX_PEND, 32'ha8);
      xfer(ipefb_pkg::IDX_PEND, 1'b1, 8'h80, 5'h0);
      rd_chk("pending w1c", ipefb_pkg::IDX_PEND, 32'h28);
      xfer(ipefb_pkg::IDX_PEND, 1'b1, 8'h28, 5'b00001);
      rd_chk("event wins", ipefb_pkg::IDX_PEND, 32'h08);
      xfer(ipefb_pkg::IDX_PEND, 1'b1, 8'h00, 5'h0);
      rd_chk("write zero", ipefb_pkg::IDX_PEND, 32'h08);
      // Every source pending and enabled, one group at level 3 at a time
      xfer(ipefb_pkg::IDX_EN_TS, 1'b1, 8'hf0, 5'b11111);
      ts_pending <= 8'hff;
      cd_pending <= 6'h3f;
      xfer(ipefb_pkg::IDX_EN_KEY, 1'b1, 8'hff, 5'h0);
      xfer(ipefb_pkg::IDX_EN_TS, 1'b1, 8'hff, 5'h0);
      xfer(ipefb_pkg::IDX_EN_CD, 1'b1, 8'hff, 5'h0);
      for (int k = 0; k < 8; k++) begin
         xfer(16'hff20, 1'b1, (k < 4) ? 8'h03 << (2 * (3 - k)) : 8'h00, 5'h0);
         xfer(16'hff21, 1'b1, (k < 4) ? 8'h00 : 8'h03 << (2 * (7 - k)), 5'h0);
         cpu_chk(1'b1, grp_t[k], 2'h3);
      end
      // Equal levels, then mask level against request level
      xfer(16'hff20, 1'b1, 8'haa, 5'h0);
      xfer(16'hff21, 1'b1, 8'haa, 5'h0);
      cpu_chk(1'b1, 3'h0, 2'h2);
      set_mask(2'h2);
      cpu_chk(1'b0, 3'h0, 2'h0);
      set_mask(2'h1);
      cpu_chk(1'b1, 3'h0, 2'h2);
      set_mask(2'h0);
      xfer(ipefb_pkg::IDX_EN_KEY, 1'b1, 8'h00, 5'h0);
      cpu_chk(1'b1, 3'h2, 2'h2);
      // Partner accepts key group 1, handler clears its flags
      xfer(ipefb_pkg::IDX_EN_KEY, 1'b1, 8'hf8, 5'h0);
      xfer(16'hff20, 1'b1, 8'hc0, 5'h0);
      // Let the level-3 request reach the output before the CPU may take it
      @(posedge pclk);
      accept_en <= 1'b1;
      cpu_chk(1'b0, 3'h0, 2'h0);
      chk("accepted group", 32'h0, {29'h0, acc_grp});
      chk("accepted mask", 32'h3, {30'h0, cpu_mask});
      accept_en <= 1'b0;
      xfer(ipefb_pkg::IDX_PEND, 1'b1, 8'hf0, 5'h0);
      set_mask(2'h0);
      cpu_chk(1'b1, 3'h4, 2'h2);
      // Sticky status, mask and the interrupt line
      xfer(ipefb_pkg::IDX_MSK, 1'b1, 8'hff, 5'h0);
      xfer(ipefb_pkg::IDX_STS, 1'b1, 8'hff, 5'h0);
      rd_chk("status cleared", ipefb_pkg::IDX_STS, 32'h0);
      chk("irq low", 32'h0, {31'h0, irq});
      xfer(ipefb_pkg::IDX_EN_KEY, 1'b1, 8'h00, 5'h0);
      xfer(ipefb_pkg::IDX_EN_KEY, 1'b1, 8'h08, 5'h0);
      rd_chk("status rise", ipefb_pkg::IDX_STS, 32'h02);
      chk("irq high", 32'h1, {31'h0, irq});
      xfer(ipefb_pkg::IDX_MSK, 1'b1, 8'hfd, 5'h0);
      repeat (2) @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      complete_run();
   end
endmodule
